// ---- rtl/vecm_pkg.sv ----
// Functional notes
// - Event when change magnitude exceeds threshold, debounced
// - Reference held inside, or from init registers
// - Internal reference never readable by host
// - Unlatched flag follows condition, drops when gone
// - Latched flag holds until status register read
// - Unlatched set debounced; clear debounced only in Dbcntm 0
// - Initm 0: capture current sample on enable
// - Initm 1: reference loads from init registers
// - Updm 0: reference takes sample on trigger
// - Updm 1: reference unchanged on trigger
// - Initm and updm: init writes apply live
// - Runs only while enabled; enable loads reference
// - Dbcntm 0: counter decrements below threshold
// - Dbcntm 1: counter clears below threshold
// - Threshold 13 bits, upper [12:8], lower [7:0]
// - Debounce period is count times sample period
// - Init values signed 14 bits, 6 plus 8
`default_nettype none
package vecm_pkg;
	// ****************************************************
	// Register offsets
	// ****************************************************
	localparam logic [6:0] OFS_INT_SOURCE  = 7'h0C;
	localparam logic [6:0] OFS_CONFIG      = 7'h5F;
	localparam logic [6:0] OFS_THS_UPPER   = 7'h60;
	localparam logic [6:0] OFS_THS_LOWER   = 7'h61;
	localparam logic [6:0] OFS_DEB_COUNT   = 7'h62;
	localparam logic [6:0] OFS_REF_X_UPPER = 7'h63;
	localparam logic [6:0] OFS_REF_X_LOWER = 7'h64;
	localparam logic [6:0] OFS_REF_Y_UPPER = 7'h65;
	localparam logic [6:0] OFS_REF_Y_LOWER = 7'h66;
	localparam logic [6:0] OFS_REF_Z_UPPER = 7'h67;
	localparam logic [6:0] OFS_REF_Z_LOWER = 7'h68;
	// ****************************************************
	// Field positions
	// ****************************************************
	localparam int BIT_LATCH    = 6;
	localparam int BIT_INITM    = 5;
	localparam int BIT_HOLDREF  = 4;
	localparam int BIT_ENABLE   = 3;
	localparam int BIT_DBCNTM   = 7;
	localparam int BIT_INT_FLAG = 1;
	localparam int THS_UP_W     = 5;
	localparam int REF_UP_W     = 6;
	localparam int SAMPLE_W     = 14;
	localparam int THS_W        = 13;
	// ****************************************************
	// Reset values and write masks
	// ****************************************************
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [7:0] CFG_MASK = 8'h78;
	localparam logic [7:0] THS_UP_MASK = 8'h9F;
	localparam logic [7:0] REF_UP_MASK = 8'h3F;
	// ****************************************************
	// Run states
	// ****************************************************
	typedef enum logic [1:0] {
		ST_OFF = 2'b01,
		ST_RUN = 2'b10
	} run_state_type;
endpackage
`default_nettype wire

// ---- rtl/vecm_magnitude.sv ----
`default_nettype none
module vecm_magnitude
	import vecm_pkg::*;
(
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       valid_i,
	input  wire logic signed [SAMPLE_W-1:0] x_i,
	input  wire logic signed [SAMPLE_W-1:0] y_i,
	input  wire logic signed [SAMPLE_W-1:0] z_i,
	input  wire logic signed [SAMPLE_W-1:0] ref_x_i,
	input  wire logic signed [SAMPLE_W-1:0] ref_y_i,
	input  wire logic signed [SAMPLE_W-1:0] ref_z_i,
	input  wire logic        [THS_W-1:0]    ths_i,
	output logic                            valid_o,
	output logic                            exceed_o
);
	// ****************************************************
	// Squared distance
	// ****************************************************
	// Squares are compared instead of a root: exact and cheap
	function automatic logic [29:0] sq_diff(
		input logic signed [SAMPLE_W-1:0] a,
		input logic signed [SAMPLE_W-1:0] b);
		logic signed [SAMPLE_W:0] d;
		logic        [SAMPLE_W:0] m;
		d = $signed({a[SAMPLE_W-1], a}) - $signed({b[SAMPLE_W-1], b});
		m = d[SAMPLE_W] ? 15'(-d) : 15'(d);
		return 30'(m * m);
	endfunction

	logic [31:0] dist_sq;
	logic [31:0] ths_sq;
	assign dist_sq = 32'(sq_diff(x_i, ref_x_i)) + 32'(sq_diff(y_i, ref_y_i))
		+ 32'(sq_diff(z_i, ref_z_i));
	assign ths_sq = 32'(ths_i * ths_i);

	// Result registered one cycle after the sample
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			valid_o  <= 1'b0;
			exceed_o <= 1'b0;
		end else begin
			valid_o <= valid_i;
			if (valid_i) begin
				exceed_o <= dist_sq > ths_sq;
			end
		end
	end

	AST_VALID_PIPE: assert property (
		@(posedge clk_i) disable iff (rst_i)
		valid_i |=> valid_o) else $error("result valid missing");
	AST_EXCEED_CALC: assert property (
		@(posedge clk_i) disable iff (rst_i)
		valid_i |=> exceed_o == $past(dist_sq > ths_sq))
		else $error("exceed result wrong");
endmodule
`default_nettype wire

// ---- rtl/vecm_detector.sv ----
`default_nettype none
module vecm_detector
	import vecm_pkg::*;
(
	input  wire logic                REF_CLK_I,
	input  wire logic                RST_I,
	input  wire logic [6:0]          REG_ADDR_I,
	input  wire logic                REG_WR_I,
	input  wire logic                REG_RD_I,
	input  wire logic [7:0]          REG_WDATA_I,
	input  wire logic                SAMPLE_VALID_I,
	input  wire logic [SAMPLE_W-1:0] SAMPLE_X_I,
	input  wire logic [SAMPLE_W-1:0] SAMPLE_Y_I,
	input  wire logic [SAMPLE_W-1:0] SAMPLE_Z_I,
	output logic      [7:0]          REG_RDATA_O,
	output logic                     EVENT_FLAG_O
);
	// ****************************************************
	// Register file
	// ****************************************************
	logic [7:0] cfg_reg;
	logic [7:0] ths_up_reg;
	logic [7:0] ths_lo_reg;
	logic [7:0] count_reg;
	logic [7:0] init_up_reg [3];
	logic [7:0] init_lo_reg [3];

	// Host writes; reserved bits are masked off at write
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cfg_reg    <= RST_REG;
			ths_up_reg <= RST_REG;
			ths_lo_reg <= RST_REG;
			count_reg  <= RST_REG;
			for (int i = 0; i < 3; i++) begin
				init_up_reg[i] <= RST_REG;
				init_lo_reg[i] <= RST_REG;
			end
		end else if (REG_WR_I) begin
			unique case (REG_ADDR_I)
				OFS_CONFIG:      cfg_reg <= REG_WDATA_I & CFG_MASK;
				OFS_THS_UPPER:   ths_up_reg <= REG_WDATA_I & THS_UP_MASK;
				OFS_THS_LOWER:   ths_lo_reg <= REG_WDATA_I;
				OFS_DEB_COUNT:   count_reg <= REG_WDATA_I;
				OFS_REF_X_UPPER: init_up_reg[0] <= REG_WDATA_I & REF_UP_MASK;
				OFS_REF_X_LOWER: init_lo_reg[0] <= REG_WDATA_I;
				OFS_REF_Y_UPPER: init_up_reg[1] <= REG_WDATA_I & REF_UP_MASK;
				OFS_REF_Y_LOWER: init_lo_reg[1] <= REG_WDATA_I;
				OFS_REF_Z_UPPER: init_up_reg[2] <= REG_WDATA_I & REF_UP_MASK;
				OFS_REF_Z_LOWER: init_lo_reg[2] <= REG_WDATA_I;
				default: ;
			endcase
		end
	end

	// Control fields
	logic latch_en;
	logic initm;
	logic holdref;
	logic func_en;
	logic dbcntm;
	logic [THS_W-1:0] ths;
	assign latch_en = cfg_reg[BIT_LATCH];
	assign initm    = cfg_reg[BIT_INITM];
	assign holdref  = cfg_reg[BIT_HOLDREF];
	assign func_en  = cfg_reg[BIT_ENABLE];
	assign dbcntm   = ths_up_reg[BIT_DBCNTM];
	assign ths      = {ths_up_reg[THS_UP_W-1:0], ths_lo_reg};

	// Signed 14-bit init values from upper and lower bytes
	logic signed [SAMPLE_W-1:0] init_val [3];
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			init_val[i] = {init_up_reg[i][REF_UP_W-1:0], init_lo_reg[i]};
		end
	end

	// ****************************************************
	// Run state and last sample
	// ****************************************************
	run_state_type state_reg;
	logic          en_rise;
	assign en_rise = state_reg == ST_OFF && func_en;

	// Enable edge seen by the state; disable drops to off
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_reg <= ST_OFF;
		end else begin
			unique case (state_reg)
				ST_OFF: if (func_en) state_reg <= ST_RUN;
				ST_RUN: if (!func_en) state_reg <= ST_OFF;
			endcase
		end
	end

	logic signed [SAMPLE_W-1:0] last_reg [3];
	// Latest output sample, the capture source for the reference
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			for (int i = 0; i < 3; i++) begin
				last_reg[i] <= '0;
			end
		end else if (SAMPLE_VALID_I) begin
			last_reg[0] <= SAMPLE_X_I;
			last_reg[1] <= SAMPLE_Y_I;
			last_reg[2] <= SAMPLE_Z_I;
		end
	end

	// ****************************************************
	// Magnitude compare
	// ****************************************************
	logic signed [SAMPLE_W-1:0] ref_reg [3];
	logic                       res_valid;
	logic                       exceed;
	logic                       running;
	assign running = state_reg == ST_RUN && func_en;

	vecm_magnitude u_mag (
		.clk_i   (REF_CLK_I),
		.rst_i   (RST_I),
		.valid_i (SAMPLE_VALID_I && running),
		.x_i     (SAMPLE_X_I),
		.y_i     (SAMPLE_Y_I),
		.z_i     (SAMPLE_Z_I),
		.ref_x_i (ref_reg[0]),
		.ref_y_i (ref_reg[1]),
		.ref_z_i (ref_reg[2]),
		.ths_i   (ths),
		.valid_o (res_valid),
		.exceed_o(exceed)
	);

	// ****************************************************
	// Debounce counter
	// ****************************************************
	logic [7:0] cnt_reg;
	logic [7:0] cnt_cur;
	logic [7:0] cnt_next;
	logic       step;
	assign step = res_valid && running;
	// Host may lower the count under a running counter: clip it
	assign cnt_cur = (cnt_reg > count_reg) ? count_reg : cnt_reg;

	// One count per sample period; saturates at the count
	always_comb begin
		cnt_next = cnt_cur;
		if (exceed) begin
			if (cnt_cur < count_reg) begin
				cnt_next = cnt_cur + 8'h01;
			end
		end else if (dbcntm) begin
			cnt_next = 8'h00;
		end else if (cnt_cur != 8'h00) begin
			cnt_next = cnt_cur - 8'h01;
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cnt_reg <= 8'h00;
		end else if (!running) begin
			cnt_reg <= 8'h00;
		end else if (step) begin
			cnt_reg <= cnt_next;
		end else begin
			cnt_reg <= cnt_cur;
		end
	end

	// ****************************************************
	// Event detection
	// ****************************************************
	logic active_reg;
	logic trigger;
	logic rt_clear;
	logic src_read;
	// Set waits on the debounce count; clear waits on it only when dbcntm is 0
	assign trigger  = step && exceed && cnt_next == count_reg && !active_reg;
	assign rt_clear = step && !exceed && cnt_next == 8'h00;
	assign src_read = REG_RD_I && REG_ADDR_I == OFS_INT_SOURCE;

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			active_reg <= 1'b0;
		end else if (!running) begin
			active_reg <= 1'b0;
		end else if (trigger) begin
			active_reg <= 1'b1;
		end else if (rt_clear) begin
			active_reg <= 1'b0;
		end
	end

	// Latched flag: a trigger in the read cycle wins
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			EVENT_FLAG_O <= 1'b0;
		end else if (!latch_en) begin
			EVENT_FLAG_O <= running && (trigger || (active_reg && !rt_clear));
		end else if (trigger) begin
			EVENT_FLAG_O <= 1'b1;
		end else if (src_read) begin
			EVENT_FLAG_O <= 1'b0;
		end
	end

	// ****************************************************
	// Reference vector
	// ****************************************************
	// Live mode tracks init registers every cycle
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			for (int i = 0; i < 3; i++) begin
				ref_reg[i] <= '0;
			end
		end else if (func_en && initm && holdref) begin
			ref_reg <= init_val;
		end else if (en_rise && initm) begin
			ref_reg <= init_val;
		end else if (en_rise) begin
			ref_reg <= last_reg;
		end else if (trigger && !holdref) begin
			ref_reg <= last_reg;
		end
	end

	// ****************************************************
	// Register readback
	// ****************************************************
	// Reference is never on the read mux; it stays hidden
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			REG_RDATA_O <= 8'h00;
		end else if (REG_RD_I) begin
			unique case (REG_ADDR_I)
				OFS_INT_SOURCE:  REG_RDATA_O <= 8'(EVENT_FLAG_O) << BIT_INT_FLAG;
				OFS_CONFIG:      REG_RDATA_O <= cfg_reg;
				OFS_THS_UPPER:   REG_RDATA_O <= ths_up_reg;
				OFS_THS_LOWER:   REG_RDATA_O <= ths_lo_reg;
				OFS_DEB_COUNT:   REG_RDATA_O <= count_reg;
				OFS_REF_X_UPPER: REG_RDATA_O <= init_up_reg[0];
				OFS_REF_X_LOWER: REG_RDATA_O <= init_lo_reg[0];
				OFS_REF_Y_UPPER: REG_RDATA_O <= init_up_reg[1];
				OFS_REF_Y_LOWER: REG_RDATA_O <= init_lo_reg[1];
				OFS_REF_Z_UPPER: REG_RDATA_O <= init_up_reg[2];
				OFS_REF_Z_LOWER: REG_RDATA_O <= init_lo_reg[2];
				default:         REG_RDATA_O <= 8'h00;
			endcase
		end
	end

	// ****************************************************
	// Checks
	// ****************************************************
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);

	sequence s_enable_init;
		state_reg == ST_OFF ##1 en_rise && initm;
	endsequence
	sequence s_enable_capture;
		state_reg == ST_OFF ##1 en_rise && !initm;
	endsequence
	sequence s_latched_set;
		latch_en && EVENT_FLAG_O && !src_read;
	endsequence

	// Flag behaviour in both latch modes
	AST_LATCH_HOLD: assert property (s_latched_set ##0 latch_en[*1]
		|=> EVENT_FLAG_O) else $error("latched flag dropped");
	AST_LATCH_SET: assert property (latch_en && trigger
		|=> EVENT_FLAG_O) else $error("latched flag not set");
	AST_READ_CLEAR: assert property (latch_en && src_read
		&& !trigger |=> !EVENT_FLAG_O)
		else $error("read did not clear");
	AST_RT_SET: assert property (!latch_en && trigger
		|=> EVENT_FLAG_O) else $error("flag did not rise");
	AST_RT_DROP: assert property (!latch_en && active_reg && rt_clear
		|=> !EVENT_FLAG_O) else $error("flag did not drop");

	// Debounce counter
	AST_CNT_SAT: assert property (running && $past(running)
		&& $stable(count_reg) |-> cnt_reg <= count_reg)
		else $error("counter above count");
	AST_CLEAR_MODE: assert property (step && !exceed && dbcntm
		|=> cnt_reg == 8'h00) else $error("counter not cleared");
	AST_DEC_MODE: assert property (step && !exceed && !dbcntm
		&& cnt_cur != 8'h00 |=> cnt_reg == $past(cnt_cur) - 8'h01)
		else $error("counter not decremented");
	AST_OFF_QUIET: assert property (!func_en ##1 !func_en
		|-> cnt_reg == 8'h00 && !active_reg)
		else $error("ran while off");

	// Reference loading and update
	AST_LIVE_REF: assert property (func_en && initm && holdref
		|=> ref_reg[0] == $past(init_val[0]))
		else $error("live ref lag");
	AST_INIT_LOAD: assert property (s_enable_init |=> ref_reg[1]
		== $past(init_val[1])) else $error("init load missed");
	AST_CAPTURE: assert property (s_enable_capture |=> ref_reg[0]
		== $past(last_reg[0])) else $error("capture missed");
	AST_TRIG_UPDATE: assert property (trigger && !holdref
		|=> ref_reg[2] == $past(last_reg[2]))
		else $error("ref not updated");
	AST_HOLD_REF: assert property (trigger && holdref && !initm
		|=> ref_reg[0] == $past(ref_reg[0])) else $error("ref moved");
endmodule
`default_nettype wire

// ---- dv/vecm_host.sv ----
`default_nettype none
module vecm_host (
	input  wire logic       clk_i,
	output logic      [6:0] addr_o,
	output logic            wr_o,
	output logic            rd_o,
	output logic      [7:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************
	// Host register cycles
	// ****************************************************
	// Idle bus at time zero
	initial begin
		addr_o = 7'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 8'h00;
	end
	// One-cycle strobe; data inverted after release so stale bytes fail
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		wdata_o = ~d;
	endtask
	// Read strobe; data is picked up by the bench one cycle later
	task automatic rd(input logic [6:0] a);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- dv/accel_vector_magnitude_detector_tb.sv ----
`default_nettype none
module accel_vector_magnitude_detector_tb
	import vecm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              REF_CLK_I = 1'b0;
	logic              RST_I;
	logic [6:0]        REG_ADDR_I;
	logic              REG_WR_I;
	logic              REG_RD_I;
	logic [7:0]        REG_WDATA_I;
	logic              SAMPLE_VALID_I;
	logic [13:0]       SAMPLE_X_I;
	logic [13:0]       SAMPLE_Y_I;
	logic [13:0]       SAMPLE_Z_I;
	logic [7:0]        REG_RDATA_O;
	logic              EVENT_FLAG_O;
	logic [7:0]        exp_q[$];
	logic              rd_seen = 1'b0;
	logic [31:0]       seed = 32'hFD34639E;
	logic [13:0]       v[6];
	logic [12:0]       t;
	logic [11:0]       pat = 12'b111011000111;
	logic [11:0]       fl = 12'b100000011100;
	int                err_count = 0;
	int                checks = 0;

	always #20 REF_CLK_I = ~REF_CLK_I;

	vecm_host i_host (.clk_i(REF_CLK_I), .addr_o(REG_ADDR_I),
		.wr_o(REG_WR_I), .rd_o(REG_RD_I), .wdata_o(REG_WDATA_I));

	vecm_detector i_dut (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
		.REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I),
		.REG_RD_I(REG_RD_I), .REG_WDATA_I(REG_WDATA_I),
		.SAMPLE_VALID_I(SAMPLE_VALID_I), .SAMPLE_X_I(SAMPLE_X_I),
		.SAMPLE_Y_I(SAMPLE_Y_I), .SAMPLE_Z_I(SAMPLE_Z_I),
		.REG_RDATA_O(REG_RDATA_O), .EVENT_FLAG_O(EVENT_FLAG_O));

	// ****************************************************
	// Checking
	// ****************************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Read data is registered, so compare one cycle after the strobe
	always @(posedge REF_CLK_I) rd_seen <= REG_RD_I;
	always @(negedge REF_CLK_I) begin
		if (rd_seen)
			chk(REG_RDATA_O, exp_q.pop_front());
	end

	// ****************************************************
	// Stimulus helpers
	// ****************************************************
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Squared distance against squared threshold, strict
	function automatic logic exc(input logic [13:0] s[6],
		input logic [12:0] th);
		longint d;
		longint acc;
		acc = 0;
		for (int i = 0; i < 3; i++) begin
			d = longint'($signed(s[i])) - longint'($signed(s[i+3]));
			acc += d * d;
		end
		return acc > longint'(th) * longint'(th);
	endfunction
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.rd(a);
	endtask
	task automatic w(input logic [6:0] a, input logic [7:0] d);
		i_host.wr(a, d);
	endtask
	// Flag pin, then status byte; status read clears a latched flag
	task automatic flag(input logic f);
		chk({7'h00, EVENT_FLAG_O}, {7'h00, f});
		rd(OFS_INT_SOURCE, {6'h00, f, 1'b0});
	endtask
	task automatic setref(input logic [13:0] x, y, z);
		w(OFS_REF_X_UPPER, {2'b00, x[13:8]});
		w(OFS_REF_X_LOWER, x[7:0]);
		w(OFS_REF_Y_UPPER, {2'b00, y[13:8]});
		w(OFS_REF_Y_LOWER, y[7:0]);
		w(OFS_REF_Z_UPPER, {2'b00, z[13:8]});
		w(OFS_REF_Z_LOWER, z[7:0]);
	endtask
	// Spacing well above three cycles, like a slow sample rate
	task automatic samp(input logic [13:0] x, y, z);
		@(negedge REF_CLK_I);
		SAMPLE_VALID_I = 1'b1;
		SAMPLE_X_I = x;
		SAMPLE_Y_I = y;
		SAMPLE_Z_I = z;
		@(negedge REF_CLK_I);
		SAMPLE_VALID_I = 1'b0;
		SAMPLE_X_I = ~x;
		repeat (3) @(negedge REF_CLK_I);
	endtask

	// Hang guard, far beyond the expected run length
	initial begin
		#2000000;
		err_count++;
		give_verdict();
	end

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		RST_I = 1'b1;
		SAMPLE_VALID_I = 1'b0;
		SAMPLE_X_I = 14'h0000;
		SAMPLE_Y_I = 14'h0000;
		SAMPLE_Z_I = 14'h0000;
		repeat (8) @(posedge REF_CLK_I);
		@(negedge REF_CLK_I);
		RST_I = 1'b0;
		// Reset values, unmapped read, reserved bits
		for (int a = 'h5F; a <= 'h68; a++) rd(7'(a), 8'h00);
		rd(7'h10, 8'h00);
		w(OFS_CONFIG, 8'hFF);
		rd(OFS_CONFIG, 8'h78);
		w(OFS_THS_UPPER, 8'hFF);
		rd(OFS_THS_UPPER, 8'h9F);
		w(OFS_REF_X_UPPER, 8'hFF);
		rd(OFS_REF_X_UPPER, 8'h3F);
		w(OFS_CONFIG, 8'h00);
		w(OFS_THS_UPPER, 8'h00);
		// Debounce: count 3, boundary sample equals threshold
		w(OFS_DEB_COUNT, 8'h03);
		w(OFS_THS_LOWER, 8'h0A);
		setref(14'h0000, 14'h0000, 14'h0000);
		w(OFS_CONFIG, 8'h38);
		for (int i = 0; i < 12; i++) begin
			if (i == 6)
				w(OFS_THS_UPPER, 8'h80);
			samp(pat[i] ? 14'd11 : 14'd10, 14'h0000, 14'h0000);
			flag(fl[i]);
		end
		// Random live reference and 11-bit threshold, count 0
		w(OFS_DEB_COUNT, 8'h00);
		for (int n = 0; n < 24; n++) begin
			for (int k = 0; k < 6; k++) begin
				v[k] = 14'($signed(xs() & 32'h3FF) - 512);
			end
			t = 13'(xs() & 32'h7FF);
			w(OFS_THS_UPPER, {3'b000, t[12:8]});
			w(OFS_THS_LOWER, t[7:0]);
			setref(v[3], v[4], v[5]);
			samp(v[0], v[1], v[2]);
			flag(exc(v, t));
		end
		// Capture on enable, then update or hold on trigger
		w(OFS_THS_UPPER, 8'h00);
		w(OFS_THS_LOWER, 8'h0A);
		for (int h = 0; h < 2; h++) begin
			w(OFS_CONFIG, 8'h00);
			setref(14'h0000, 14'h0000, 14'h0000);
			samp(14'd100, 14'h0000, 14'h0000);
			flag(1'b0);
			w(OFS_CONFIG, h ? 8'h18 : 8'h08);
			samp(14'd100, 14'h0000, 14'h0000);
			flag(1'b0);
			samp(14'd200, 14'h0000, 14'h0000);
			flag(1'b1);
			samp(14'd200, 14'h0000, 14'h0000);
			flag(h[0]);
			rd(OFS_REF_X_LOWER, 8'h00);
		end
		// Latched flag survives quiet sample and disable until read
		w(OFS_CONFIG, 8'h00);
		setref(14'h0000, 14'h0000, 14'h0000);
		w(OFS_CONFIG, 8'h78);
		samp(14'd11, 14'h0000, 14'h0000);
		samp(14'h0000, 14'h0000, 14'h0000);
		w(OFS_CONFIG, 8'h40);
		flag(1'b1);
		flag(1'b0);
		repeat (4) @(negedge REF_CLK_I);
		give_verdict();
	end
endmodule
`default_nettype wire
